// *** src/lbs_timing.sv ***
`timescale 1ns/1ps
module lbs_timing #(
  parameter int SLOT_CYCLES = lbs_pkg::SLOT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel C outputs
  output logic             chan_c_on_output,
  output logic             tick_8ms_out
);

  lbs_pkg::lbs_cfg_t   cfg_reg;
  lbs_pkg::lbs_state_t state_reg;
  logic [31:0] slot_cnt_reg;
  logic [4:0]  slot_reg;
  logic [2:0]  t8_reg;
  logic [6:0]  seg_cnt_reg;
  logic        slot_tick;
  logic        tick_8ms;
  logic        tick_64ms;
  logic        wr_en;
  logic        hit;
  logic [7:0]  rd_byte;
  logic [6:0]  seg_len;
  logic [4:0]  duty_reg;
  logic        seq_run;
  logic        on_now;
  logic        on_prev_reg;
  logic        on_enter;
  logic        on_leave;
  logic [4:0]  rise_cnt_reg;
  logic [4:0]  fall_cnt_reg;
  logic        rise_active_reg;
  logic        fall_active_reg;

  function automatic logic [11:0] reg_addr(input logic [11:0] idx);
    reg_addr = {idx[9:0], 2'b00};
  endfunction

  // Last tick of a ramp window; six bits so that a length shortened
  // in mid-window still closes it instead of waiting for a wrap
  function automatic logic ramp_last(input logic [4:0] cnt,
                                     input logic [4:0] len);
    ramp_last = (({1'b0, cnt} + 6'h01) >= {1'b0, len});
  endfunction

  // Slot, 8 ms and 64 ms ticks by counting the fast clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slot_cnt_reg <= 32'h0;
      slot_reg     <= 5'h0;
      t8_reg       <= 3'h0;
    end else if (slot_tick) begin
      slot_cnt_reg <= 32'h0;
      slot_reg     <= slot_reg + 5'h1;
      if (tick_8ms) begin
        t8_reg <= t8_reg + 3'h1;
      end
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h1;
    end
  end

  assign slot_tick = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));
  assign tick_8ms  = slot_tick && (slot_reg == 5'(lbs_pkg::SLOTS_8MS - 1));
  assign tick_64ms = tick_8ms && (t8_reg == 3'(lbs_pkg::TICKS_64MS - 1));

  // APB decode; slave answers with zero wait states
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      reg_addr(lbs_pkg::IDX_SEG2):   rd_byte = {1'b0, cfg_reg.seg2};
      reg_addr(lbs_pkg::IDX_SEG3):   rd_byte = {1'b0, cfg_reg.seg3};
      reg_addr(lbs_pkg::IDX_SEG4):   rd_byte = {1'b0, cfg_reg.seg4};
      reg_addr(lbs_pkg::IDX_PAUSE):  rd_byte = {1'b0, cfg_reg.pause};
      reg_addr(lbs_pkg::IDX_DUTY):   rd_byte = {3'h0, cfg_reg.duty};
      reg_addr(lbs_pkg::IDX_ONTIME): rd_byte = {3'h0, cfg_reg.on_time};
      reg_addr(lbs_pkg::IDX_RISE):   rd_byte = {3'h0, cfg_reg.rise};
      reg_addr(lbs_pkg::IDX_FALL):   rd_byte = {3'h0, cfg_reg.fall};
      reg_addr(lbs_pkg::IDX_ENABLE): rd_byte = cfg_reg.enables;
      reg_addr(lbs_pkg::IDX_STATUS):
        rd_byte = {3'h0, fall_active_reg, rise_active_reg, state_reg};
      default:                       hit     = 1'b0;
    endcase
  end

  // Register writes; masks keep unused bits at zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_reg <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        reg_addr(lbs_pkg::IDX_SEG2):   cfg_reg.seg2    <= pwdata[6:0];
        reg_addr(lbs_pkg::IDX_SEG3):   cfg_reg.seg3    <= pwdata[6:0];
        reg_addr(lbs_pkg::IDX_SEG4):   cfg_reg.seg4    <= pwdata[6:0];
        reg_addr(lbs_pkg::IDX_PAUSE):  cfg_reg.pause   <= pwdata[6:0];
        reg_addr(lbs_pkg::IDX_DUTY):   cfg_reg.duty    <= pwdata[4:0];
        reg_addr(lbs_pkg::IDX_ONTIME): cfg_reg.on_time <= pwdata[4:0];
        reg_addr(lbs_pkg::IDX_RISE):   cfg_reg.rise    <= pwdata[4:0];
        reg_addr(lbs_pkg::IDX_FALL):   cfg_reg.fall    <= pwdata[4:0];
        reg_addr(lbs_pkg::IDX_ENABLE):
          cfg_reg.enables <= pwdata[7:0] & lbs_pkg::MASK_ENABLE;
        default: ;
      endcase
    end
  end

  // Registered APB answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // Length of the segment being run, in 64 ms ticks
  always_comb begin
    unique case (state_reg)
      lbs_pkg::LBS_ON:    seg_len = {2'b00, cfg_reg.on_time};
      lbs_pkg::LBS_SEG2:  seg_len = cfg_reg.seg2;
      lbs_pkg::LBS_SEG3:  seg_len = cfg_reg.seg3;
      lbs_pkg::LBS_SEG4:  seg_len = cfg_reg.seg4;
      lbs_pkg::LBS_PAUSE: seg_len = cfg_reg.pause;
      default:            seg_len = 7'h0;
    endcase
  end

  // Sequencer; zero-length segments pass through in one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg   <= lbs_pkg::LBS_IDLE;
      seg_cnt_reg <= 7'h0;
    end else if (!cfg_reg.enables[lbs_pkg::POS_SEQ_EN] ||
                 !cfg_reg.enables[lbs_pkg::POS_CHAN_EN]) begin
      state_reg   <= lbs_pkg::LBS_IDLE;
      seg_cnt_reg <= 7'h0;
    end else if (state_reg == lbs_pkg::LBS_IDLE) begin
      state_reg   <= lbs_pkg::LBS_ON;
      seg_cnt_reg <= 7'h0;
    end else if (seg_cnt_reg >= seg_len) begin
      seg_cnt_reg <= 7'h0;
      unique case (state_reg)
        lbs_pkg::LBS_ON:   state_reg <= lbs_pkg::LBS_SEG2;
        lbs_pkg::LBS_SEG2: state_reg <= lbs_pkg::LBS_SEG3;
        lbs_pkg::LBS_SEG3: state_reg <= lbs_pkg::LBS_SEG4;
        lbs_pkg::LBS_SEG4: state_reg <= lbs_pkg::LBS_PAUSE;
        default:           state_reg <= lbs_pkg::LBS_ON;
      endcase
    end else if (tick_64ms) begin
      seg_cnt_reg <= seg_cnt_reg + 7'h1;
    end
  end

  // Duty taken at the period boundary so that a write in mid-period
  // cannot leave a runt pulse; costs up to one period of latency
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      duty_reg <= 5'h0;
    end else if (tick_8ms) begin
      duty_reg <= cfg_reg.duty;
    end
  end

  // Sequencer running needs both enables; on segment edges
  assign seq_run  = cfg_reg.enables[lbs_pkg::POS_SEQ_EN] &&
                    cfg_reg.enables[lbs_pkg::POS_CHAN_EN];
  assign on_now   = (state_reg == lbs_pkg::LBS_ON);
  assign on_enter = on_now && !on_prev_reg;
  assign on_leave = !on_now && on_prev_reg;

  // History of the on segment; resets to idle level, so no false edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= on_now;
    end
  end

  // Ramp-up window, opened as the on segment starts; counts free
  // running 8 ms ticks, so it is exact only to one tick
  always_ff @(posedge clock) begin
    if (!rst_n || !seq_run) begin
      rise_cnt_reg    <= 5'h0;
      rise_active_reg <= 1'b0;
    end else if (on_enter) begin
      rise_cnt_reg    <= 5'h0;
      rise_active_reg <= (cfg_reg.rise != 5'h0);
    end else if (on_leave) begin
      rise_cnt_reg    <= 5'h0;
      rise_active_reg <= 1'b0;
    end else if (rise_active_reg && tick_8ms) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h1;
      if (ramp_last(rise_cnt_reg, cfg_reg.rise)) begin
        rise_active_reg <= 1'b0;
      end
    end
  end

  // Ramp-down window, opened as the on segment ends; a new on
  // segment cuts it short
  always_ff @(posedge clock) begin
    if (!rst_n || !seq_run) begin
      fall_cnt_reg    <= 5'h0;
      fall_active_reg <= 1'b0;
    end else if (on_leave) begin
      fall_cnt_reg    <= 5'h0;
      fall_active_reg <= (cfg_reg.fall != 5'h0);
    end else if (on_enter) begin
      fall_cnt_reg    <= 5'h0;
      fall_active_reg <= 1'b0;
    end else if (fall_active_reg && tick_8ms) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h1;
      if (ramp_last(fall_cnt_reg, cfg_reg.fall)) begin
        fall_active_reg <= 1'b0;
      end
    end
  end

  // PWM output; sequencer off means plain PWM while channel enabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chan_c_on_output <= 1'b0;
      tick_8ms_out     <= 1'b0;
    end else begin
      tick_8ms_out <= tick_8ms;
      if (!cfg_reg.enables[lbs_pkg::POS_CHAN_EN]) begin
        chan_c_on_output <= 1'b0;
      end else if (cfg_reg.enables[lbs_pkg::POS_SEQ_EN] &&
                   state_reg != lbs_pkg::LBS_ON) begin
        chan_c_on_output <= 1'b0;
      end else if (duty_reg == lbs_pkg::DUTY_MAX) begin
        chan_c_on_output <= 1'b1;
      end else begin
        chan_c_on_output <= (slot_reg <= duty_reg);
      end
    end
  end

endmodule  // lbs_timing

// *** src/lbs_pkg.sv ***
package lbs_pkg;

  // Register indexes; the bus byte address is four times the index
  localparam logic [11:0] IDX_SEG2   = 12'h059;
  localparam logic [11:0] IDX_SEG3   = 12'h05a;
  localparam logic [11:0] IDX_SEG4   = 12'h05b;
  localparam logic [11:0] IDX_PAUSE  = 12'h05c;
  localparam logic [11:0] IDX_DUTY   = 12'h05d;
  localparam logic [11:0] IDX_ONTIME = 12'h05e;
  localparam logic [11:0] IDX_RISE   = 12'h05f;
  localparam logic [11:0] IDX_FALL   = 12'h060;
  localparam logic [11:0] IDX_ENABLE = 12'h061;
  localparam logic [11:0] IDX_STATUS = 12'h070;

  // Field masks for writable bits
  localparam logic [7:0] MASK_SEG7   = 8'h7f;
  localparam logic [7:0] MASK_FIVE   = 8'h1f;
  localparam logic [7:0] MASK_ENABLE = 8'h77;
  localparam int         POS_CHAN_EN = 4;
  localparam int         POS_SEQ_EN  = 0;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Time bases
  localparam int CLOCK_HZ   = 100_000_000;
  localparam int SLOT_US    = 250;
  localparam int SLOT_CYC   = CLOCK_HZ / 1_000_000 * SLOT_US;
  localparam int SLOTS_8MS  = 32;
  localparam int TICKS_64MS = 8;
  localparam logic [4:0] DUTY_MAX = 5'h1f;

  typedef enum logic [2:0] {
    LBS_IDLE, LBS_ON, LBS_SEG2, LBS_SEG3, LBS_SEG4, LBS_PAUSE
  } lbs_state_t;

  typedef struct packed {
    logic [6:0] seg2;
    logic [6:0] seg3;
    logic [6:0] seg4;
    logic [6:0] pause;
    logic [4:0] duty;
    logic [4:0] on_time;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [7:0] enables;
  } lbs_cfg_t;

endpackage

// *** sim/lbs_timing_properties.sv ***
`timescale 1ns/1ps
module lbs_timing_chk (
  // Clock, reset and APB requests
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Answers and channel outputs
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chan_c_on_output,
  input wire logic        tick_8ms_out
);
  logic [7:0] en_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow of the enables, taken at the same edge the write lands
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_reg <= 8'h00;
    end else if (pready && pwrite && paddr == 12'h184) begin
      en_reg <= pwdata[7:0] & 8'h77;
    end
  end
  // Bus answers, reset, time base and channel disable
  access_ready_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  err_unmapped_a: assert property (pready && paddr == 12'h000 |-> pslverr)
    else $error("unmapped access not refused");
  err_paired_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  reset_quiet_a: assert property ($rose(rst_n) |-> !chan_c_on_output)
    else $error("output high after reset");
  tick_pulse_a: assert property (tick_8ms_out |=> !tick_8ms_out)
    else $error("tick longer than one cycle");
  chan_off_a: assert property (!en_reg[4] [*3] |-> !chan_c_on_output)
    else $error("output high while disabled");
endmodule // lbs_timing_chk

bind lbs_timing lbs_timing_chk chk (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_c_on_output(chan_c_on_output), .tick_8ms_out(tick_8ms_out));

// *** sim/lbs_timing_bench.sv ***
`timescale 1ns/1ps
module lbs_timing_bench;
  typedef struct {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
  } lbs_row_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        led;
  logic        tk;
  int          errors = 0;
  int          tests_run = 0;
  int          hi;
  int          tks;
  int          dv [3] = '{0, 15, 31};
  lbs_row_t    rows [10] = '{
    '{12'h164, 8'hff, 8'h7f}, '{12'h168, 8'h80, 8'h00},
    '{12'h16c, 8'h7f, 8'h7f}, '{12'h170, 8'h81, 8'h01},
    '{12'h174, 8'he0, 8'h00}, '{12'h178, 8'hff, 8'h1f},
    '{12'h17c, 8'hff, 8'h1f}, '{12'h180, 8'h3e, 8'h1e},
    '{12'h184, 8'hff, 8'h77}, '{12'h000, 8'hff, 8'h00}};
  // Short slots keep an 8 ms period at 128 cycles
  lbs_timing #(.SLOT_CYCLES(4)) DUT (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_c_on_output(led), .tick_8ms_out(tk));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Settle two periods, then count high cycles and ticks; an unknown
  // counts as high so that it cannot pass a zero check
  task automatic meas(input int n);
    repeat (256) @(posedge clock);
    hi = 0;
    tks = 0;
    repeat (n) begin
      @(posedge clock);
      hi += int'(led !== 1'b0);
      tks += int'(tk !== 1'b0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 8'h00);
      chk(rd, 32'h0);
    end
    $display("reset values done");
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].w);
      apb(rows[i].a, 1'b0, 8'h00);
      chk(rd, {24'h0, rows[i].e});
      chk({31'h0, er}, {31'h0, rows[i].a == 12'h000});
    end
    $display("register rows done");
    apb(12'h184, 1'b1, 8'h10);
    foreach (dv[i]) begin
      apb(12'h174, 1'b1, dv[i][7:0]);
      meas(128);
      chk(hi, (dv[i] + 1) * 4);
      chk(tks, 1);
    end
    apb(12'h1c0, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(12'h184, 1'b1, 8'h00);
    meas(128);
    chk(hi, 0);
    $display("pwm and disable done");
    // Five ticks a round; once aligned only the two-tick on part is lit
    apb(12'h164, 1'b1, 8'h01);
    apb(12'h16c, 1'b1, 8'h01);
    apb(12'h178, 1'b1, 8'h02);
    apb(12'h184, 1'b1, 8'h11);
    repeat (8192) @(posedge clock);
    meas(5120);
    chk(hi, 2 * 8 * 32 * 4);
    chk(tks, 40);
    apb(12'h1c0, 1'b0, 8'h00);
    chk({31'h0, rd[2:0] != 3'h0 && rd[2:0] < 3'h6}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(12'h184, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(12'h1c0, 1'b0, 8'h00);
    chk(rd, 32'h0);
    $display("sequence and second reset done");
    test_done;
  end
endmodule // lbs_timing_bench
